// ---- design/adcc_control.sv ----
`timescale 1ns/100ps
`include "adcc_regs.svh"

// Overview of operation
// [R1] wait mode converts and wakes on interrupt; stop mode disables, no wake
// [R2] power bit 4 clear switches converter off, set switches it on
// [R3] converter on exactly while power bit is one; power resets to zero (code also holds it off in stop mode)
// [R4] end flag bit 6 read-only; cleared only by starting a conversion
// [R5] completion sets end flag; request raised only with enable bit 7
// [R6] writing one to start bit 5 starts and clears end flag; zero ignored
// [R7] start during a conversion abandons it and begins a fresh one
// [R8] start bit always reads back as zero
// [R9] software keeps reserved control bits 3, 1 and 0 at zero
// [R10] control bit 2 drives main oscillator disable, not the converter
// [R11] eight-bit result in read-only register at index D0
// [R12] software trusts result only while end flag reads one
// [R13] control register at index D1 resets to 40h
// [R14] interrupt routine should clear the enable bit
// [R15] software should wait with timer stopped for best accuracy
// [R16] software powers on at least one instruction before starting
// [R17] input above high reference gives FFh, below low gives 00h
// [R18] sequencer resolves bits msb first in fixed cycles, then flags

module adcc_control #(
    parameter int BIT_CYCLES = `ADCC_BIT_CYC
) (
    input wire logic aclk, // core clock
    input wire logic aresetn, // sync reset, active low
    input wire logic ce, // clock enable, freezes state
    input wire adcc_pkg::adcc_axil_req_t axil_req, // axi4-lite master side
    output adcc_pkg::adcc_axil_rsp_t axil_rsp, // axi4-lite slave answer
    input wire logic cmp_i, // comparator: input >= trial
    input wire logic wait_mode_i, // core in wait mode
    input wire logic stop_mode_i, // core in stop mode
    output logic [7:0] dac_trial_o, // trial code to dac
    output logic converter_power_o, // analog part powered
    output logic main_osc_disable_o, // to clock system
    output logic conv_irq_req_o, // end-of-conversion request
    output logic wake_o, // wake from wait mode
    output logic irq_o // masked sticky status
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_bad_bit_cycles
        $error("BIT_CYCLES must lie in 1..255");
    end

    localparam logic [7:0] BIT_RELOAD = 8'(BIT_CYCLES - 1);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic adcc_pkg::adcc_sel_t adcc_decode(
        input logic [11:0] a
    );
        adcc_pkg::adcc_sel_t s;
        s = adcc_pkg::ADCC_SEL_NONE;
        if (a[1:0] == 2'h0) begin
            unique case (a[11:2])
                {2'h0, `ADCC_IDX_RESULT}: s = adcc_pkg::ADCC_SEL_RESULT;
                {2'h0, `ADCC_IDX_CTRL}: s = adcc_pkg::ADCC_SEL_CTRL;
                {2'h0, `ADCC_IDX_STAT}: s = adcc_pkg::ADCC_SEL_STAT;
                {2'h0, `ADCC_IDX_MASK}: s = adcc_pkg::ADCC_SEL_MASK;
                default: s = adcc_pkg::ADCC_SEL_NONE;
            endcase
        end
        return s;
    endfunction : adcc_decode

    adcc_pkg::adcc_state_t r_reg;
    adcc_pkg::adcc_state_t r_next;

    logic conv_on;
    logic do_wr;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic start_wr;
    logic ctrl_wr;
    logic done_ev;
    logic abort_ev;
    logic [1:0] stat_clr;
    logic [7:0] ctrl_view;
    logic [7:0] bit_mask;
    adcc_pkg::adcc_sel_t wsel;
    adcc_pkg::adcc_sel_t rsel;

    // stop mode disables the converter regardless of the power bit
    assign conv_on = r_reg.power && !stop_mode_i;
    assign bit_mask = 8'h01 << r_reg.bit_idx;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        wsel = adcc_decode(r_reg.aw_addr);
        rsel = adcc_decode(axil_req.araddr);
        aw_take = axil_req.awvalid && !r_reg.aw_full && !r_reg.bvalid;
        w_take = axil_req.wvalid && !r_reg.w_full && !r_reg.bvalid;
        ar_take = axil_req.arvalid && !r_reg.rvalid;
        do_wr = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
        ctrl_wr = do_wr && r_reg.wstrb0 && wsel == adcc_pkg::ADCC_SEL_CTRL;
        // [R6] only a one starts
        start_wr = ctrl_wr && r_reg.wdata[`ADCC_CTRL_START];
        stat_clr = 2'h0;
        done_ev = 1'b0;
        abort_ev = 1'b0;
        // [R8] start bit reads zero
        ctrl_view = {r_reg.irq_en, r_reg.eoc, 1'b0, r_reg.power,
            1'b0, r_reg.osc_off, 2'h0};

        // write address and data are taken in either order
        if (aw_take) begin
            r_next.aw_full = 1'b1;
            r_next.aw_addr = axil_req.awaddr;
        end
        if (w_take) begin
            r_next.w_full = 1'b1;
            r_next.wdata = axil_req.wdata[7:0];
            r_next.wstrb0 = axil_req.wstrb[0];
        end
        if (r_reg.bvalid && axil_req.bready) begin
            r_next.bvalid = 1'b0;
        end

        if (do_wr) begin
            r_next.aw_full = 1'b0;
            r_next.w_full = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `ADCC_RESP_OKAY;
            if (wsel == adcc_pkg::ADCC_SEL_NONE) begin
                r_next.bresp = `ADCC_RESP_SLVERR;
            end
            if (r_reg.wstrb0) begin
                unique case (wsel)
                    adcc_pkg::ADCC_SEL_CTRL: begin
                        r_next.irq_en = r_reg.wdata[`ADCC_CTRL_IRQ_EN];
                        // [R2] power bit write
                        r_next.power = r_reg.wdata[`ADCC_CTRL_POWER];
                        // [R10] oscillator disable bit
                        r_next.osc_off = r_reg.wdata[`ADCC_CTRL_OSC_OFF];
                    end
                    adcc_pkg::ADCC_SEL_STAT: stat_clr = r_reg.wdata[1:0];
                    adcc_pkg::ADCC_SEL_MASK: r_next.mask = r_reg.wdata[1:0];
                    default: ;
                endcase
            end
        end

        // read channel, one outstanding read
        if (r_reg.rvalid && axil_req.rready) begin
            r_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = `ADCC_RESP_OKAY;
            r_next.rdata = 32'h0000_0000;
            unique case (rsel)
                // [R11] result register
                adcc_pkg::ADCC_SEL_RESULT: r_next.rdata[7:0] = r_reg.result;
                adcc_pkg::ADCC_SEL_CTRL: r_next.rdata[7:0] = ctrl_view;
                adcc_pkg::ADCC_SEL_STAT: r_next.rdata[1:0] = r_reg.status;
                adcc_pkg::ADCC_SEL_MASK: r_next.rdata[1:0] = r_reg.mask;
                adcc_pkg::ADCC_SEL_NONE: r_next.rresp = `ADCC_RESP_SLVERR;
            endcase
        end

        // --------------------------------------------------------
        // successive approximation
        // --------------------------------------------------------
        unique case (r_reg.fsm)
            adcc_pkg::ADCC_IDLE: ;
            adcc_pkg::ADCC_CONV: begin
                if (r_reg.cnt != 8'h00) begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end else begin
                    // [R17] all-high comparisons saturate at full scale
                    if (!cmp_i) begin
                        r_next.trial = r_reg.trial & ~bit_mask;
                    end
                    if (r_reg.bit_idx == 3'h0) begin
                        // [R18] last bit loads result and flags
                        r_next.result = cmp_i ? r_reg.trial
                            : (r_reg.trial & ~bit_mask);
                        // [R5] completion sets the end flag
                        r_next.eoc = 1'b1;
                        r_next.fsm = adcc_pkg::ADCC_IDLE;
                        done_ev = 1'b1;
                    end else begin
                        // [R18] next bit down, msb first
                        r_next.bit_idx = r_reg.bit_idx - 3'h1;
                        r_next.trial[r_reg.bit_idx - 3'h1] = 1'b1;
                        r_next.cnt = BIT_RELOAD;
                    end
                end
            end
        endcase

        // [R1] stop mode abandons any conversion
        if (!conv_on) begin
            r_next.fsm = adcc_pkg::ADCC_IDLE;
            done_ev = 1'b0;
            r_next.eoc = r_reg.eoc;
            r_next.result = r_reg.result;
        end

        // [R4] only a start clears the end flag
        if (start_wr) begin
            r_next.eoc = 1'b0;
            done_ev = 1'b0;
            // [R7] restart abandons running conversion
            abort_ev = r_reg.fsm == adcc_pkg::ADCC_CONV;
            if (conv_on) begin
                r_next.fsm = adcc_pkg::ADCC_CONV;
                r_next.bit_idx = 3'h7;
                r_next.trial = 8'h80;
                r_next.cnt = BIT_RELOAD;
            end
        end

        // sticky status, a set wins over a clear
        r_next.status = (r_reg.status & ~stat_clr)
            | {abort_ev, done_ev};
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            // [R13] control reset value
            r_reg.eoc <= 1'(`ADCC_CTRL_RESET >> `ADCC_CTRL_EOC);
            r_reg.status <= `ADCC_STAT_RESET;
            r_reg.mask <= `ADCC_MASK_RESET;
            r_reg.fsm <= adcc_pkg::ADCC_IDLE;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        axil_rsp.awready = !r_reg.aw_full && !r_reg.bvalid;
        axil_rsp.wready = !r_reg.w_full && !r_reg.bvalid;
        axil_rsp.bvalid = r_reg.bvalid;
        axil_rsp.bresp = r_reg.bresp;
        axil_rsp.arready = !r_reg.rvalid;
        axil_rsp.rvalid = r_reg.rvalid;
        axil_rsp.rdata = r_reg.rdata;
        axil_rsp.rresp = r_reg.rresp;
    end

    assign dac_trial_o = r_reg.trial;
    // [R3] analog part follows the power bit, forced off in stop mode
    assign converter_power_o = conv_on;
    assign main_osc_disable_o = r_reg.osc_off;
    // [R5] request gated by enable
    assign conv_irq_req_o = r_reg.irq_en && r_reg.eoc;
    // [R1] wake only from wait, never from stop
    assign wake_o = conv_irq_req_o && wait_mode_i && !stop_mode_i;
    assign irq_o = |(r_reg.status & r_reg.mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_stop_no_wake; // [R1]
        stop_mode_i |-> !wake_o && !converter_power_o;
    endproperty
    a_stop_no_wake: assert property (p_stop_no_wake)
        else $error("wake or power active in stop mode");

    property p_power_follows; // [R2]
        ce && ctrl_wr |=> r_reg.power == $past(r_reg.wdata[4]);
    endproperty
    a_power_follows: assert property (p_power_follows)
        else $error("power bit did not follow write");

    property p_power_out; // [R3]
        converter_power_o |-> ctrl_view[`ADCC_CTRL_POWER];
    endproperty
    a_power_out: assert property (p_power_out)
        else $error("converter on while power bit zero");

    property p_eoc_fall; // [R4]
        $fell(r_reg.eoc) |-> $past(start_wr) && $past(ce);
    endproperty
    a_eoc_fall: assert property (p_eoc_fall)
        else $error("end flag cleared without a start");

    property p_done_sets; // [R5]
        ce && done_ev && !start_wr |=> r_reg.eoc ##0 r_reg.status[0];
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("completion did not set end flag");

    property p_start_clears; // [R6]
        ce && start_wr |=> !r_reg.eoc;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not clear end flag");

    property p_restart; // [R7]
        ce && start_wr && conv_on |=> r_reg.fsm == adcc_pkg::ADCC_CONV
            && r_reg.bit_idx == 3'h7 && dac_trial_o == 8'h80;
    endproperty
    a_restart: assert property (p_restart)
        else $error("start did not begin a fresh conversion");

    property p_start_reads_zero; // [R8]
        ce && ar_take && rsel == adcc_pkg::ADCC_SEL_CTRL
            |=> axil_rsp.rvalid && !axil_rsp.rdata[5];
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero)
        else $error("start bit read back as one");

    property p_done_point; // [R18]
        done_ev |-> r_reg.bit_idx == 3'h0 && r_reg.cnt == 8'h00
            && r_reg.fsm == adcc_pkg::ADCC_CONV;
    endproperty
    a_done_point: assert property (p_done_point)
        else $error("completion outside last bit slot");

endmodule : adcc_control

// ---- inc/adcc_pkg.sv ----
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_CONV
    } adcc_fsm_t;

    typedef enum logic [2:0] {
        ADCC_SEL_NONE,
        ADCC_SEL_RESULT,
        ADCC_SEL_CTRL,
        ADCC_SEL_STAT,
        ADCC_SEL_MASK
    } adcc_sel_t;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } adcc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } adcc_axil_rsp_t;

    typedef struct packed {
        logic aw_full;
        logic [11:0] aw_addr;
        logic w_full;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq_en;
        logic eoc;
        logic power;
        logic osc_off;
        logic [7:0] result;
        logic [7:0] trial;
        logic [2:0] bit_idx;
        logic [7:0] cnt;
        adcc_fsm_t fsm;
        logic [1:0] status;
        logic [1:0] mask;
    } adcc_state_t;

endpackage : adcc_pkg

// ---- inc/adcc_regs.svh ----
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_RESULT 8'hD0
`define ADCC_IDX_CTRL 8'hD1
`define ADCC_IDX_STAT 8'hD5
`define ADCC_IDX_MASK 8'hD6

// control register fields
`define ADCC_CTRL_IRQ_EN 7
`define ADCC_CTRL_EOC 6
`define ADCC_CTRL_START 5
`define ADCC_CTRL_POWER 4
`define ADCC_CTRL_OSC_OFF 2
`define ADCC_CTRL_RESET 8'h40

// status and mask fields
`define ADCC_STAT_DONE 0
`define ADCC_STAT_ABORT 1
`define ADCC_STAT_RESET 2'h0
`define ADCC_MASK_RESET 2'h0

// timing
`define ADCC_CLK_MHZ 50
`define ADCC_BIT_TIME_NS 100
`define ADCC_BIT_CYC ((`ADCC_BIT_TIME_NS * `ADCC_CLK_MHZ + 999) / 1000)

// axi responses
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// ---- tb/adcc_analog_model.sv ----
`timescale 1ns/100ps

module adcc_analog_model (
    input wire logic aclk, // core clock
    input wire logic powered, // converter power
    input wire logic [7:0] trial, // trial code from sequencer
    input wire logic [7:0] vin, // input level in lsb units
    output logic cmp // comparator output
);
    // -------------------------------------------------
    // comparator
    // -------------------------------------------------
    logic junk_reg = 1'b0;

    // unpowered comparator gives no stable answer
    always @(posedge aclk) begin
        junk_reg <= ~junk_reg;
    end

    assign cmp = powered ? (vin >= trial) : junk_reg;
endmodule : adcc_analog_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "adcc_regs.svh"

module testbench;
    // -------------------------------------------------
    // signals
    // -------------------------------------------------
    localparam logic [11:0] A_RES = {2'h0, `ADCC_IDX_RESULT, 2'h0};
    localparam logic [11:0] A_CTL = {2'h0, `ADCC_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STA = {2'h0, `ADCC_IDX_STAT, 2'h0};
    localparam logic [11:0] A_MSK = {2'h0, `ADCC_IDX_MASK, 2'h0};
    logic aclk, aresetn, ce, wait_mode, stop_mode, cmp;
    logic power, osc_off, conv_irq, wake, irq;
    logic [7:0] trial, vin;
    logic [1:0] rs;
    logic [31:0] rd;
    adcc_pkg::adcc_axil_req_t req;
    adcc_pkg::adcc_axil_rsp_t rsp;
    int err_count, n_checks;
    logic [7:0] lv [3] = '{8'hff, 8'h00, 8'h5a};

    adcc_control #(.BIT_CYCLES(2)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .axil_req(req), .axil_rsp(rsp), .cmp_i(cmp),
        .wait_mode_i(wait_mode), .stop_mode_i(stop_mode),
        .dac_trial_o(trial), .converter_power_o(power),
        .main_osc_disable_o(osc_off), .conv_irq_req_o(conv_irq),
        .wake_o(wake), .irq_o(irq)
    );

    adcc_analog_model model_u (
        .aclk(aclk), .powered(power), .trial(trial), .vin(vin),
        .cmp(cmp)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // -------------------------------------------------
    // tasks
    // -------------------------------------------------
    task automatic end_sim;
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb, b;
        b = 1'b0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h00_0000, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        for (int n = 0; n < 100 && !b; n++) begin
            @(negedge aclk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid;
            rs = rsp.bresp;
            @(posedge aclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) begin
                b = 1'b1;
                req.bready <= 1'b0;
            end
        end
        if (!b) begin
            err_count++;
            end_sim();
        end
    endtask : wr

    task automatic rd_raw(input logic [11:0] a);
        logic ta, tv, g;
        g = 1'b0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (int n = 0; n < 100 && !g; n++) begin
            @(negedge aclk);
            ta = req.arvalid && rsp.arready;
            tv = rsp.rvalid;
            rd = rsp.rdata;
            rs = rsp.rresp;
            @(posedge aclk);
            if (ta) req.arvalid <= 1'b0;
            if (tv) begin
                g = 1'b1;
                req.rready <= 1'b0;
            end
        end
        if (!g) begin
            err_count++;
            end_sim();
        end
    endtask : rd_raw

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rd_raw(a);
        chk($sformatf("reg %h", a), rd, e);
        chk("rresp", {30'h0, rs}, {30'h0, `ADCC_RESP_OKAY});
    endtask : rchk

    // start, check immediate clear, then poll for end flag
    task automatic conv(input logic [7:0] c);
        wr(A_CTL, c);
        rchk(A_CTL, {24'h00_0000, c & 8'hdf});
        for (int n = 0; n < 40; n++) begin
            rd_raw(A_CTL);
            if (rd[6] === 1'b1) break;
        end
        if (rd[6] !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask : conv

    // -------------------------------------------------
    // sequence
    // -------------------------------------------------
    initial begin
        aresetn = 1'b0;
        req = '0;
        ce = 1'b1;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        vin = 8'ha5;
        err_count = 0;
        n_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(A_CTL, 32'h0000_0040);
        rchk(A_RES, 32'h0000_0000);
        rchk(A_STA, 32'h0000_0000);
        rchk(A_MSK, 32'h0000_0000);
        chk("power", power, 1'b0);
        // power on ahead of start; reserved bits zero
        wr(A_CTL, 8'h10);
        chk("power", power, 1'b1);
        wr(A_CTL, 8'h14);
        chk("osc", osc_off, 1'b1);
        rchk(A_CTL, 32'h0000_0054);
        wr(A_CTL, 8'h10);
        chk("osc", osc_off, 1'b0);
        for (int i = 0; i < 3; i++) begin
            vin <= lv[i];
            conv(8'h30);
            rchk(A_RES, {24'h00_0000, lv[i]});
            chk("irq", irq, 1'b0);
        end
        wr(A_CTL, 8'h10);
        rchk(A_CTL, 32'h0000_0050);
        wr(A_MSK, 8'h01);
        chk("irq", irq, 1'b1);
        wr(A_STA, 8'h01);
        chk("irq", irq, 1'b0);
        rchk(A_STA, 32'h0000_0000);
        wr(A_CTL, 8'h90);
        chk("conv_irq", conv_irq, 1'b1);
        wr(A_CTL, 8'h10);
        chk("conv_irq", conv_irq, 1'b0);
        // restart mid conversion with a new level
        vin <= 8'h5a;
        wr(A_CTL, 8'h30);
        ce <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("trial", trial, 8'h80);
        ce <= 1'b1;
        vin <= 8'h3c;
        conv(8'h30);
        rchk(A_RES, 32'h0000_003c);
        rchk(A_STA, 32'h0000_0003);
        // wait mode, woken by end of conversion
        wait_mode <= 1'b1;
        conv(8'hb0);
        chk("wake", wake, 1'b1);
        wr(A_CTL, 8'h10);
        chk("wake", wake, 1'b0);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        wr(A_CTL, 8'h30);
        chk("power", power, 1'b0);
        repeat (30) @(posedge aclk);
        rchk(A_CTL, 32'h0000_0010);
        stop_mode <= 1'b0;
        rd_raw(12'h000);
        chk("rresp", {30'h0, rs}, {30'h0, `ADCC_RESP_SLVERR});
        chk("rdata", rd, 32'h0000_0000);
        wr(12'h000, 8'hff);
        chk("bresp", {30'h0, rs}, {30'h0, `ADCC_RESP_SLVERR});
        end_sim();
    end
endmodule : testbench
